// [src/timer_pkg.sv]
// Package: register map, field layout, reset values and state types of the dual timer
package timer_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_A_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_A_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_B_CTRL1 = 8'h08;
  localparam logic [7:0] OFF_B_CTRL2 = 8'h0c;
  localparam logic [7:0] OFF_REL_HI = 8'h10;
  localparam logic [7:0] OFF_A_REL = 8'h14;
  localparam logic [7:0] OFF_B_REL = 8'h18;
  localparam logic [7:0] OFF_A_DUTY = 8'h1c;
  localparam logic [7:0] OFF_B_DUTY = 8'h20;
  localparam logic [7:0] OFF_BZ_A = 8'h24;
  localparam logic [7:0] OFF_BZ_B = 8'h28;
  localparam logic [7:0] OFF_IRQ_FLAG = 8'h2c;
  localparam logic [7:0] OFF_IRQ_EN = 8'h30;
  localparam logic [7:0] OFF_A_PCNT = 8'h34;
  localparam logic [7:0] OFF_B_PCNT = 8'h38;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C1_PWM_EN = 7;
  localparam int C1_ACT_LOW = 6;
  localparam int C1_FAST = 3;
  localparam int C1_ONE_SHOT = 2;
  localparam int C1_RELOAD_SEL = 1;
  localparam int C1_RUN = 0;
  localparam int C2_SRC = 5;
  localparam int C2_EDGE = 4;
  localparam int C2_PRE_N = 3;
  localparam int RH_A_DUTY = 0;
  localparam int RH_B_DUTY = 2;
  localparam int RH_A_REL = 4;
  localparam int RH_B_REL = 6;
  localparam int BZ_EN = 7;
  localparam int IRQ_A_BIT = 3;
  localparam int IRQ_B_BIT = 5;
  localparam int GIE_BIT = 7;

  // ----------------------------------------------------------------
  // Reset values, write masks, counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h08;
  localparam logic [7:0] A_CTRL1_MASK = 8'hc7;
  localparam logic [7:0] B_CTRL1_MASK = 8'hcf;
  localparam logic [7:0] CTRL2_MASK = 8'h3f;
  localparam logic [7:0] BZ_MASK = 8'h8f;
  localparam logic [9:0] RELOAD_FULL = 10'h3ff;
  localparam logic [1:0] INSTR_LAST = 2'h3;

  typedef struct packed {
    logic run;
    logic one_shot;
    logic reload_sel;
    logic fast_sel;
    logic src_sel;
    logic edge_sel;
    logic pre_en_n;
    logic [2:0] pre_rate;
    logic act_low;
    logic [3:0] bz_sel;
  } tmr_cfg_t;

  typedef struct packed {
    logic [9:0] cnt;
    logic [7:0] pcnt;
    logic uf;
    logic pwm;
    logic bz;
  } tmr_stat_t;

  typedef struct packed {
    logic [9:0] cnt;
    logic [9:0] reload;
    logic [9:0] duty;
    logic [9:0] pend;
    logic [7:0] pcnt;
    logic [7:0] bcnt;
    logic done;
    logic uf;
    logic pwm;
    logic bz;
  } unit_state_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [1:0] div;
    logic [7:0] a_c1;
    logic [7:0] a_c2;
    logic [7:0] b_c1;
    logic [7:0] b_c2;
    logic [7:0] rel_hi;
    logic [7:0] bz_a;
    logic [7:0] bz_b;
    logic [1:0] flag;
    logic [1:0] ien;
    logic global_irq_enable;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic pa_o;
    logic pa_oe;
    logic pb1_o;
    logic pb1_oe;
    logic pb2_o;
    logic pb2_oe;
  } top_state_t;

  localparam top_state_t TOP_RST = '{a_c2: CTRL2_RST, b_c2: CTRL2_RST, default: '0};

  // Low n bits set; used by prescaler and buzzer dividers
  function automatic logic [7:0] ones_below(input logic [3:0] n);
    logic [8:0] t;
    t = (9'h001 << n) - 9'h001;
    ones_below = t[7:0];
  endfunction : ones_below

endpackage : timer_pkg

// [src/timer_unit.sv]
// Timer unit: prescaler, 10-bit down counter, PWM and buzzer divider
`timescale 1ns/10ps
module timer_unit (
  input wire logic mclk,
  input wire logic rst,
  input timer_pkg::tmr_cfg_t cfg,
  input wire logic instr_tick,
  input wire logic ext_rise,
  input wire logic ext_fall,
  input wire logic fast_tick,
  input wire logic [1:0] rel_hi,
  input wire logic [1:0] duty_hi,
  input wire logic [7:0] wr_byte,
  input wire logic wr_reload,
  input wire logic wr_duty,
  output timer_pkg::tmr_stat_t st
);
  import timer_pkg::*;

  unit_state_t s_q;
  unit_state_t s_d;
  logic src_tick;
  logic ps_tick;
  logic cnt_tick;
  logic bz_src;

  // Source select, prescaler, counter, PWM and buzzer
  always_comb begin
    s_d = s_q;
    s_d.uf = 1'b0;
    if (cfg.fast_sel) begin
      src_tick = fast_tick;
    end else if (cfg.src_sel) begin
      src_tick = cfg.edge_sel ? ext_fall : ext_rise;
    end else begin
      src_tick = instr_tick;
    end
    src_tick = src_tick & cfg.run;
    ps_tick = src_tick && ((s_q.pcnt & ones_below({1'b0, cfg.pre_rate} + 4'h1))
      == ones_below({1'b0, cfg.pre_rate} + 4'h1));
    if (src_tick) begin
      s_d.pcnt = s_q.pcnt + 8'h01;
    end
    cnt_tick = cfg.pre_en_n ? src_tick : ps_tick;
    if (wr_duty) begin
      s_d.pend = {duty_hi, wr_byte};
    end
    if (!cfg.run) begin
      s_d.done = 1'b0;
    end else if (cnt_tick && !s_q.done) begin
      if (s_q.cnt == 10'h000) begin
        s_d.uf = 1'b1;
        s_d.duty = s_q.pend;
        if (cfg.one_shot) begin
          s_d.done = 1'b1;
        end else begin
          s_d.cnt = cfg.reload_sel ? s_q.reload : RELOAD_FULL;
        end
      end else begin
        s_d.cnt = s_q.cnt - 10'h001;
      end
    end
    if (wr_reload) begin
      s_d.reload = {rel_hi, wr_byte};
      if (!cfg.run) begin
        s_d.cnt = {rel_hi, wr_byte};
      end
    end
    s_d.pwm = (s_q.cnt < s_q.duty) ^ cfg.act_low;
    bz_src = cfg.bz_sel[3] ? s_d.uf : ps_tick;
    if (bz_src) begin
      s_d.bcnt = s_q.bcnt + 8'h01;
      if ((s_q.bcnt & ones_below({1'b0, cfg.bz_sel[2:0]})) ==
          ones_below({1'b0, cfg.bz_sel[2:0]})) begin
        s_d.bz = ~s_q.bz;
      end
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign st = '{cnt: s_q.cnt, pcnt: s_q.pcnt, uf: s_q.uf, pwm: s_q.pwm, bz: s_q.bz};

  uf_cause_a: assert property (
    @(posedge mclk) disable iff (rst) s_q.uf |-> $past(s_q.cnt) == 10'h000)
    else $error("underflow without zero count");
  oneshot_stop_a: assert property (
    @(posedge mclk) disable iff (rst) (s_q.uf && cfg.one_shot && cfg.run) |=> s_q.cnt == 10'h000)
    else $error("one-shot counter moved after underflow");
  cont_reload_a: assert property (
    @(posedge mclk) disable iff (rst) (s_q.uf && $past(cfg.run) && !$past(cfg.one_shot)
      && !$past(wr_reload)) |-> s_q.cnt == ($past(cfg.reload_sel) ? $past(s_q.reload) : 10'h3ff))
    else $error("wrong restart value");
  idle_load_a: assert property (
    @(posedge mclk) disable iff (rst) (wr_reload && !cfg.run) |=> s_q.cnt == {$past(rel_hi), $past(wr_byte)})
    else $error("idle reload not immediate");
  duty_swap_a: assert property (
    @(posedge mclk) disable iff (rst) (s_q.duty != $past(s_q.duty)) |-> s_q.uf)
    else $error("duty changed outside underflow");
  duty_zero_a: assert property (
    @(posedge mclk) disable iff (rst) (s_q.duty == 10'h000) |=> s_q.pwm == $past(cfg.act_low))
    else $error("pwm active with zero duty");

endmodule : timer_unit

// [src/dual_timer.sv]
// Dual down-count timer with PWM and buzzer outputs behind an APB slave
`timescale 1ns/10ps

// Function
// - Timer A: prescaled 10-bit down counter, underflow drives outputs
// - Reload buffered; running timer loads at overflow
// - Stopped timer loads reload on low write
// - Reading timer returns live count
// - Run bit enables counting; clear stops
// - Fast oscillator, external pin, or instruction clock
// - Edge-select picks falling or rising external edge
// - Active-low prescaler enable, rates 1:2..1:256, readable
// - One-shot counts down once then stops
// - Continuous restarts from reload or 0x3FF
// - Underflow sets flag; irq needs enables; write-0 clears
// - PWM enable drives pin as output
// - Polarity bit selects active low
// - 10-bit duty; zero never active
// - Duty buffered, applied at next overflow
// - Buzzer enable drives shared pin as output
// - Buzzer source timer or prescaler, divided
// - PWM wins over buzzer on pin
// - Timer B mirrors A with own bits
// - PWM B on both pins, duty bits 3:2
// - Buzzer B drives its pin, same selection
module dual_timer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clock_pin_0,
  input wire logic ext_clock_pin_1,
  input wire logic internal_fast_osc,
  output logic irq,
  output logic pwm_a_pin_o,
  output logic pwm_a_pin_oe,
  output logic pwm_b_pin_first_o,
  output logic pwm_b_pin_first_oe,
  output logic pwm_b_pin_second_o,
  output logic pwm_b_pin_second_oe
);
  import timer_pkg::*;

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  top_state_t s_q;
  top_state_t s_d;
  tmr_cfg_t cfg_a;
  tmr_cfg_t cfg_b;
  tmr_stat_t st_a;
  tmr_stat_t st_b;
  logic instr_tick;
  logic [2:0] rise;
  logic [2:0] fall;
  logic setup;
  logic wr;
  logic [31:0] rdata;
  logic hit_any;
  logic wr_a_rel;
  logic wr_b_rel;
  logic wr_a_duty;
  logic wr_b_duty;

  // Address match of a register offset, word aligned
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    reg_hit = (a[7:2] == off[7:2]);
  endfunction : reg_hit

  // ----------------------------------------------------------------
  // Pin synchronisers and clock-source ticks
  // ----------------------------------------------------------------
  // Edges come from the second and third stage only; stage one feeds
  // nothing but stage two. The fast oscillator is sampled too, so it
  // only counts correctly while it is well below half of mclk.
  always_comb begin
    rise = s_q.s2 & ~s_q.s3;
    fall = ~s_q.s2 & s_q.s3;
    instr_tick = (s_q.div == INSTR_LAST);
  end

  // ----------------------------------------------------------------
  // Timer configuration from control registers
  // ----------------------------------------------------------------
  // Fast oscillator select lives in timer B's first control register
  always_comb begin
    cfg_a.run = s_q.a_c1[C1_RUN];
    cfg_a.one_shot = s_q.a_c1[C1_ONE_SHOT];
    cfg_a.reload_sel = s_q.a_c1[C1_RELOAD_SEL];
    cfg_a.fast_sel = s_q.b_c1[C1_FAST];
    cfg_a.src_sel = s_q.a_c2[C2_SRC];
    cfg_a.edge_sel = s_q.a_c2[C2_EDGE];
    cfg_a.pre_en_n = s_q.a_c2[C2_PRE_N];
    cfg_a.pre_rate = s_q.a_c2[2:0];
    cfg_a.act_low = s_q.a_c1[C1_ACT_LOW];
    cfg_a.bz_sel = s_q.bz_a[3:0];
    cfg_b.run = s_q.b_c1[C1_RUN];
    cfg_b.one_shot = s_q.b_c1[C1_ONE_SHOT];
    cfg_b.reload_sel = s_q.b_c1[C1_RELOAD_SEL];
    cfg_b.fast_sel = s_q.b_c1[C1_FAST];
    cfg_b.src_sel = s_q.b_c2[C2_SRC];
    cfg_b.edge_sel = s_q.b_c2[C2_EDGE];
    cfg_b.pre_en_n = s_q.b_c2[C2_PRE_N];
    cfg_b.pre_rate = s_q.b_c2[2:0];
    cfg_b.act_low = s_q.b_c1[C1_ACT_LOW];
    cfg_b.bz_sel = s_q.bz_b[3:0];
  end

  // ----------------------------------------------------------------
  // APB decode and read mux
  // ----------------------------------------------------------------
  // Read data is captured in the setup cycle; counts may move by the
  // access cycle, which is acceptable for a live count.
  always_comb begin
    setup = psel & ~penable;
    wr = psel & penable & s_q.pready & pwrite;
    rdata = 32'h0000_0000;
    hit_any = 1'b1;
    if (reg_hit(paddr, OFF_A_CTRL1)) begin
      rdata[7:0] = s_q.a_c1;
    end else if (reg_hit(paddr, OFF_A_CTRL2)) begin
      rdata[7:0] = s_q.a_c2;
    end else if (reg_hit(paddr, OFF_B_CTRL1)) begin
      rdata[7:0] = s_q.b_c1;
    end else if (reg_hit(paddr, OFF_B_CTRL2)) begin
      rdata[7:0] = s_q.b_c2;
    end else if (reg_hit(paddr, OFF_REL_HI)) begin
      rdata[7:0] = s_q.rel_hi;
    end else if (reg_hit(paddr, OFF_A_REL)) begin
      rdata[9:0] = st_a.cnt;
    end else if (reg_hit(paddr, OFF_B_REL)) begin
      rdata[9:0] = st_b.cnt;
    end else if (reg_hit(paddr, OFF_A_DUTY)) begin
      rdata = 32'h0000_0000;
    end else if (reg_hit(paddr, OFF_B_DUTY)) begin
      rdata = 32'h0000_0000;
    end else if (reg_hit(paddr, OFF_BZ_A)) begin
      rdata[7:0] = s_q.bz_a;
    end else if (reg_hit(paddr, OFF_BZ_B)) begin
      rdata[7:0] = s_q.bz_b;
    end else if (reg_hit(paddr, OFF_IRQ_FLAG)) begin
      rdata[IRQ_A_BIT] = s_q.flag[0];
      rdata[IRQ_B_BIT] = s_q.flag[1];
    end else if (reg_hit(paddr, OFF_IRQ_EN)) begin
      rdata[IRQ_A_BIT] = s_q.ien[0];
      rdata[IRQ_B_BIT] = s_q.ien[1];
      rdata[GIE_BIT] = s_q.global_irq_enable;
    end else if (reg_hit(paddr, OFF_A_PCNT)) begin
      rdata[7:0] = st_a.pcnt;
    end else if (reg_hit(paddr, OFF_B_PCNT)) begin
      rdata[7:0] = st_b.pcnt;
    end else begin
      hit_any = 1'b0;
    end
  end

  // Write strobes into the timer units
  always_comb begin
    wr_a_rel = wr & reg_hit(paddr, OFF_A_REL);
    wr_b_rel = wr & reg_hit(paddr, OFF_B_REL);
    wr_a_duty = wr & reg_hit(paddr, OFF_A_DUTY);
    wr_b_duty = wr & reg_hit(paddr, OFF_B_DUTY);
  end

  // ----------------------------------------------------------------
  // Timer units
  // ----------------------------------------------------------------
  timer_unit unit_a (
    .mclk(mclk),
    .rst(rst),
    .cfg(cfg_a),
    .instr_tick(instr_tick),
    .ext_rise(rise[0]),
    .ext_fall(fall[0]),
    .fast_tick(rise[2]),
    .rel_hi(s_q.rel_hi[RH_A_REL +: 2]),
    .duty_hi(s_q.rel_hi[RH_A_DUTY +: 2]),
    .wr_byte(pwdata[7:0]),
    .wr_reload(wr_a_rel),
    .wr_duty(wr_a_duty),
    .st(st_a)
  );

  timer_unit unit_b (
    .mclk(mclk),
    .rst(rst),
    .cfg(cfg_b),
    .instr_tick(instr_tick),
    .ext_rise(rise[1]),
    .ext_fall(fall[1]),
    .fast_tick(rise[2]),
    .rel_hi(s_q.rel_hi[RH_B_REL +: 2]),
    .duty_hi(s_q.rel_hi[RH_B_DUTY +: 2]),
    .wr_byte(pwdata[7:0]),
    .wr_reload(wr_b_rel),
    .wr_duty(wr_b_duty),
    .st(st_b)
  );

  // ----------------------------------------------------------------
  // Next state: sync, divider, registers, flags, pins
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.s1 = {internal_fast_osc, ext_clock_pin_1, ext_clock_pin_0};
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.div = instr_tick ? 2'h0 : s_q.div + 2'h1;
    // Zero-wait slave: ready rises in the first access cycle
    s_d.pready = setup;
    s_d.pslverr = setup & ~hit_any;
    if (setup) begin
      s_d.prdata = pwrite ? 32'h0000_0000 : rdata;
    end
    if (wr) begin
      if (reg_hit(paddr, OFF_A_CTRL1)) begin
        s_d.a_c1 = pwdata[7:0] & A_CTRL1_MASK;
      end
      if (reg_hit(paddr, OFF_A_CTRL2)) begin
        s_d.a_c2 = pwdata[7:0] & CTRL2_MASK;
      end
      if (reg_hit(paddr, OFF_B_CTRL1)) begin
        s_d.b_c1 = pwdata[7:0] & B_CTRL1_MASK;
      end
      if (reg_hit(paddr, OFF_B_CTRL2)) begin
        s_d.b_c2 = pwdata[7:0] & CTRL2_MASK;
      end
      if (reg_hit(paddr, OFF_REL_HI)) begin
        s_d.rel_hi = pwdata[7:0];
      end
      if (reg_hit(paddr, OFF_BZ_A)) begin
        s_d.bz_a = pwdata[7:0] & BZ_MASK;
      end
      if (reg_hit(paddr, OFF_BZ_B)) begin
        s_d.bz_b = pwdata[7:0] & BZ_MASK;
      end
      if (reg_hit(paddr, OFF_IRQ_FLAG)) begin
        // Writing 0 clears, writing 1 leaves the flag alone
        s_d.flag = s_q.flag & {pwdata[IRQ_B_BIT], pwdata[IRQ_A_BIT]};
      end
      if (reg_hit(paddr, OFF_IRQ_EN)) begin
        s_d.ien = {pwdata[IRQ_B_BIT], pwdata[IRQ_A_BIT]};
        s_d.global_irq_enable = pwdata[GIE_BIT];
      end
    end
    // Hardware set applied last so it wins over a same-cycle clear
    s_d.flag = s_d.flag | {st_b.uf, st_a.uf};
    s_d.irq = s_q.global_irq_enable & |(s_q.flag & s_q.ien);
    // Pin A: PWM has priority over the buzzer
    s_d.pa_oe = s_q.a_c1[C1_PWM_EN] | s_q.bz_a[BZ_EN];
    if (s_q.a_c1[C1_PWM_EN]) begin
      s_d.pa_o = st_a.pwm;
    end else begin
      s_d.pa_o = s_q.bz_a[BZ_EN] & st_a.bz;
    end
    // First pin B is shared by PWM B and buzzer B
    s_d.pb1_oe = s_q.b_c1[C1_PWM_EN] | s_q.bz_b[BZ_EN];
    if (s_q.b_c1[C1_PWM_EN]) begin
      s_d.pb1_o = st_b.pwm;
    end else begin
      s_d.pb1_o = s_q.bz_b[BZ_EN] & st_b.bz;
    end
    // Second pin B carries PWM B only
    s_d.pb2_oe = s_q.b_c1[C1_PWM_EN];
    s_d.pb2_o = s_q.b_c1[C1_PWM_EN] & st_b.pwm;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= TOP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign irq = s_q.irq;
  assign pwm_a_pin_o = s_q.pa_o;
  assign pwm_a_pin_oe = s_q.pa_oe;
  assign pwm_b_pin_first_o = s_q.pb1_o;
  assign pwm_b_pin_first_oe = s_q.pb1_oe;
  assign pwm_b_pin_second_o = s_q.pb2_o;
  assign pwm_b_pin_second_oe = s_q.pb2_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  flag_set_a: assert property (
    @(posedge mclk) disable iff (rst) st_a.uf |=> s_q.flag[0])
    else $error("underflow A did not set flag");
  flag_clear_a: assert property (
    @(posedge mclk) disable iff (rst) $fell(s_q.flag[1]) |->
      $past(wr && reg_hit(paddr, OFF_IRQ_FLAG) && !pwdata[IRQ_B_BIT]))
    else $error("flag B cleared without write of zero");
  irq_gate_a: assert property (
    @(posedge mclk) disable iff (rst) ##1 s_q.irq == $past(s_q.global_irq_enable && |(s_q.flag & s_q.ien)))
    else $error("interrupt request gating wrong");
  pin_prio_a: assert property (
    @(posedge mclk) disable iff (rst) s_q.a_c1[C1_PWM_EN] |=> s_q.pa_oe && s_q.pa_o == $past(st_a.pwm))
    else $error("pin A not carrying PWM");
  pinb_prio_a: assert property (
    @(posedge mclk) disable iff (rst) s_q.b_c1[C1_PWM_EN] |=>
      s_q.pb1_oe && s_q.pb2_oe && s_q.pb1_o == $past(st_b.pwm))
    else $error("pins B not carrying PWM");

endmodule : dual_timer

// [test/test_dual_timer.sv]
// Testbench for the dual down-count timer: bus, counting, flags and pins
`timescale 1ns/10ps
module test_dual_timer;
  import timer_pkg::*;
  // ----------------------------------------
  // Signals and case table
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
    logic er;
  } row_t;
  localparam row_t ROWS [9] = '{
    '{1'b0, OFF_A_CTRL1, 8'h00, CTRL1_RST, 1'b0},
    '{1'b0, OFF_A_CTRL2, 8'h00, CTRL2_RST, 1'b0},
    '{1'b0, OFF_B_CTRL2, 8'h00, CTRL2_RST, 1'b0},
    '{1'b0, OFF_IRQ_FLAG, 8'h00, 8'h00, 1'b0},
    '{1'b1, OFF_A_CTRL2, 8'hff, 8'h3f, 1'b0},
    '{1'b1, OFF_A_CTRL2, 8'h08, 8'h08, 1'b0},
    '{1'b1, OFF_A_PCNT, 8'hff, 8'h00, 1'b0},
    '{1'b0, 8'h3c, 8'h00, 8'h00, 1'b1},
    '{1'b1, 8'h3c, 8'hff, 8'h00, 1'b1}
  };
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic ext0 = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, pa_o, pa_oe, pb1_o, pb1_oe, pb2_o, pb2_oe;
  logic [31:0] q;
  logic serr;
  logic [1:0] seen;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;

  dual_timer i_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_clock_pin_0(ext0),
    .ext_clock_pin_1(1'b0), .internal_fast_osc(1'b0), .irq(irq),
    .pwm_a_pin_o(pa_o), .pwm_a_pin_oe(pa_oe), .pwm_b_pin_first_o(pb1_o),
    .pwm_b_pin_first_oe(pb1_oe), .pwm_b_pin_second_o(pb2_o),
    .pwm_b_pin_second_oe(pb2_oe));

  // 40 MHz clock; cycle ceiling cuts a hang short
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic conclude();
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk

  task automatic bchk(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask : bchk

  // One APB transfer; pready is seen as it stood at the sampling edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    bchk("pready", 1'b1, pready);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask : rd

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 4000) begin
      @(posedge mclk);
      n++;
    end
    bchk("irq", 1'b1, irq);
  endtask : wait_irq

  // k+1 rising and k falling edges, pin left high
  task automatic pulses(input int k);
    repeat (k) begin
      repeat (4) @(posedge mclk);
      ext0 <= 1'b1;
      repeat (4) @(posedge mclk);
      ext0 <= 1'b0;
    end
    repeat (4) @(posedge mclk);
    ext0 <= 1'b1;
    repeat (12) @(posedge mclk);
  endtask : pulses

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a, {24'h0, ROWS[i].e});
      bchk("slverr", ROWS[i].er, serr);
    end
    // Stopped timer takes the reload at once; read shows the count
    wr(OFF_REL_HI, 8'h10);
    wr(OFF_A_REL, 8'h05);
    rd(OFF_A_REL, 32'h105);
    wr(OFF_IRQ_EN, 8'h88);
    wr(OFF_A_CTRL1, 8'h05);
    wait_irq();
    repeat (40) @(posedge mclk);
    rd(OFF_A_REL, 32'h0);
    rd(OFF_IRQ_FLAG, 32'h08);
    wr(OFF_IRQ_FLAG, 8'h00);
    rd(OFF_IRQ_FLAG, 32'h0);
    bchk("irq low", 1'b0, irq);
    // Continuous restart from reload or from full scale
    for (int s = 0; s < 2; s++) begin
      wr(OFF_A_CTRL1, 8'h00);
      wr(OFF_REL_HI, 8'h00);
      wr(OFF_A_REL, 8'h03);
      wr(OFF_A_CTRL1, s ? 8'h03 : 8'h01);
      wait_irq();
      wr(OFF_IRQ_FLAG, 8'h00);
      apb(1'b0, OFF_A_REL, 32'h0);
      bchk("restart", 1'b1, s ? (q[9:0] <= 10'h003) : (q[9:0] >= 10'h3f0));
    end
    // External pin, rising then falling edge
    for (int e = 0; e < 2; e++) begin
      wr(OFF_A_CTRL1, 8'h00);
      ext0 <= 1'b0;
      wr(OFF_A_CTRL2, e ? 8'h38 : 8'h28);
      wr(OFF_A_REL, 8'h10);
      wr(OFF_A_CTRL1, 8'h01);
      pulses(4);
      rd(OFF_A_REL, e ? 32'h00c : 32'h00b);
    end
    // Prescaler on, rate /2; buzzer alone must toggle the pin
    wr(OFF_A_CTRL2, 8'h00);
    wr(OFF_BZ_A, 8'h80);
    seen = 2'b00;
    repeat (300) begin
      @(posedge mclk);
      if (pa_o === 1'b1) seen[1] = 1'b1;
      if (pa_o === 1'b0) seen[0] = 1'b1;
    end
    bchk("buzzer oe", 1'b1, pa_oe);
    bchk("buzzer toggles", 1'b1, &seen);
    // Zero duty: PWM stays inactive and hides the buzzer
    for (int p = 0; p < 2; p++) begin
      wr(OFF_A_CTRL1, p ? 8'hc1 : 8'h81);
      repeat (8) @(posedge mclk);
      repeat (32) begin
        @(posedge mclk);
        bchk("pwm oe", 1'b1, pa_oe);
        bchk("pwm level", p[0], pa_o);
      end
    end
    // Nonzero duty kept within the reload; applied at the next underflow
    wr(OFF_A_CTRL1, 8'h00);
    wr(OFF_REL_HI, 8'h00);
    wr(OFF_A_REL, 8'h10);
    wr(OFF_A_DUTY, 8'h08);
    wr(OFF_A_CTRL1, 8'h83);
    seen = 2'b00;
    repeat (400) begin
      @(posedge mclk);
      if (pa_o === 1'b1) seen[1] = 1'b1;
      if (pa_o === 1'b0) seen[0] = 1'b1;
    end
    bchk("pwm duty", 1'b1, &seen);
    // Timer B: both pins, its own flag bit, PWM over buzzer
    wr(OFF_B_REL, 8'h04);
    wr(OFF_B_CTRL1, 8'h83);
    wr(OFF_BZ_B, 8'h80);
    repeat (60) @(posedge mclk);
    bchk("pwm b first oe", 1'b1, pb1_oe);
    bchk("pwm b second oe", 1'b1, pb2_oe);
    bchk("pwm b first", 1'b0, pb1_o);
    apb(1'b0, OFF_IRQ_FLAG, 32'h0);
    bchk("flag b", 1'b1, q[IRQ_B_BIT]);
    wr(OFF_B_CTRL1, 8'h01);
    repeat (4) @(posedge mclk);
    bchk("buzzer b oe", 1'b1, pb1_oe);
    bchk("second pin off", 1'b0, pb2_oe);
    // Reset in mid-run clears pins and registers
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    bchk("oe in reset", 1'b0, pa_oe | pb1_oe | pb2_oe);
    bchk("irq in reset", 1'b0, irq);
    rst <= 1'b0;
    rd(OFF_B_CTRL1, 32'h0);
    conclude();
  end
endmodule : test_dual_timer
